// ===== inc/hrf_pkg.sv
// Shared constants and types for the receive FIFO scheduler
package hrf_pkg;

    // ==================================================================
    // Sizes
    localparam int NUM_PORTS     = 16;
    localparam int NUM_FAST      = 2;
    localparam int PORT_W        = 4;
    localparam int NUM_CH        = 256;
    localparam int CH_W          = 8;
    localparam int DW            = 32;
    localparam int STORE_BYTES   = 16384;
    localparam int BLOCK_BYTES   = 16;
    localparam int WORD_BYTES    = 4;
    localparam int STORE_WORDS   = STORE_BYTES / WORD_BYTES;
    localparam int REGION_WORDS  = STORE_WORDS / NUM_CH;
    localparam int BLOCK_WORDS   = BLOCK_BYTES / WORD_BYTES;
    localparam int PTR_W         = 4;
    localparam int ADDR_W        = CH_W + PTR_W;
    localparam int FILL_W        = 5;
    localparam int HWM_W         = 3;
    localparam int BLK_SHIFT     = 2;
    localparam int OUT_W         = DW + CH_W + 2;

    // ==================================================================
    // Values after reset, full-region fill and one-word fill step
    localparam logic [FILL_W-1:0] FILL_RESET   = 5'h00;
    localparam logic [PTR_W-1:0]  PTR_RESET    = 4'h0;
    localparam logic [CH_W-1:0]   RR_RESET     = 8'h00;
    localparam logic [FILL_W-1:0] REGION_FULL  = 5'h10;
    localparam logic [FILL_W-1:0] FILL_ONE     = 5'h01;

    // ==================================================================
    // Scheduler states
    typedef enum logic [0:0] {
        HRF_IDLE,
        HRF_SERVE
    } hrf_state_e;

endpackage

// ===== src/hrf_skid_buf.sv
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/1ps
module hrf_skid_buf #(
    parameter int W = 42
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    logic         skid_valid;
    logic [W-1:0] skid_data;
    logic         next_out_valid;
    logic [W-1:0] next_out_data;
    logic         next_skid_valid;
    logic [W-1:0] next_skid_data;

    assign in_ready = ~skid_valid;

    // ==================================================================
    // Next values
    always_comb begin
        next_out_valid  = out_valid;
        next_out_data   = out_data;
        next_skid_valid = skid_valid;
        next_skid_data  = skid_data;
        if (out_ready || !out_valid) begin
            if (skid_valid) begin
                next_out_valid  = 1'b1;
                next_out_data   = skid_data;
                next_skid_valid = 1'b0;
            end else begin
                next_out_valid = in_valid;
                next_out_data  = in_data;
            end
        end else if (in_valid && !skid_valid) begin
            // Output stalled: park the word so nothing is lost
            next_skid_valid = 1'b1;
            next_skid_data  = in_data;
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid  <= 1'b0;
            out_data   <= '0;
            skid_valid <= 1'b0;
            skid_data  <= '0;
        end else begin
            out_valid  <= next_out_valid;
            out_data   <= next_out_data;
            skid_valid <= next_skid_valid;
            skid_data  <= next_skid_data;
        end
    end

endmodule

// ===== src/hrf_rx_sched.sv
// Receive FIFO: engine arbitration, per-channel store and DMA scheduling
`timescale 1ns/1ps
module hrf_rx_sched
    import hrf_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Host configuration
    input  wire logic [NUM_FAST-1:0]       receive_port_control,
    input  wire logic [HWM_W-1:0]          high_mark_blocks,
    input  wire logic                      rr_mode,
    // Normal engines
    input  wire logic [NUM_PORTS-1:0]      engine_req,
    input  wire logic [NUM_PORTS*CH_W-1:0] engine_ch,
    input  wire logic [NUM_PORTS*DW-1:0]   engine_data,
    input  wire logic [NUM_PORTS-1:0]      engine_eof,
    output logic [NUM_PORTS-1:0]           engine_ack,
    // Fast engines on ports 0 and 1
    input  wire logic [NUM_FAST-1:0]       fast_req,
    input  wire logic [NUM_FAST*CH_W-1:0]  fast_ch,
    input  wire logic [NUM_FAST*DW-1:0]    fast_data,
    input  wire logic [NUM_FAST-1:0]       fast_eof,
    output logic [NUM_FAST-1:0]            fast_ack,
    // DMA scheduling
    output logic                           dma_req,
    output logic                           dma_busy,
    output logic [CH_W-1:0]                dma_sel_ch,
    // DMA data
    output logic                           dma_valid,
    input  wire logic                      dma_ready,
    output logic [DW-1:0]                  dma_data,
    output logic [CH_W-1:0]                dma_ch,
    output logic                           dma_eof,
    output logic                           dma_last
);

    // ==================================================================
    // Functions
    function automatic logic [CH_W:0] first_set(input logic [NUM_CH-1:0] v);
        logic [CH_W:0] r;
        r = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, CH_W'(i)};
            end
        end
        return r;
    endfunction

    // ==================================================================
    // Storage
    logic [DW:0]         store    [STORE_WORDS];
    logic [FILL_W-1:0]   fill     [NUM_CH];
    logic [PTR_W-1:0]    wr_ptr   [NUM_CH];
    logic [PTR_W-1:0]    rd_ptr   [NUM_CH];
    logic [NUM_CH-1:0]   eof_pend;

    // ==================================================================
    // Scheduler state
    hrf_state_e          state;
    hrf_state_e          next_state;
    logic [CH_W-1:0]     cur_ch;
    logic [CH_W-1:0]     next_cur_ch;
    logic [CH_W-1:0]     rr_ptr;
    logic [CH_W-1:0]     next_rr_ptr;
    logic                next_dma_req;
    logic                next_dma_busy;
    logic [NUM_PORTS-1:0] next_engine_ack;
    logic [NUM_FAST-1:0] next_fast_ack;

    // ==================================================================
    // Engine side
    logic [CH_W-1:0]      eff_ch   [NUM_PORTS];
    logic [DW-1:0]        eff_data [NUM_PORTS];
    logic [NUM_PORTS-1:0] eff_req;
    logic [NUM_PORTS-1:0] eff_eof;
    logic [NUM_PORTS-1:0] eligible;
    logic [NUM_PORTS-1:0] ack_any;
    logic [CH_W:0]        port_pick;
    logic                 wr_en;
    logic [PORT_W-1:0]    wr_port;
    logic [CH_W-1:0]      wr_ch;
    logic [DW-1:0]        wr_data;
    logic                 wr_eof;
    logic [ADDR_W-1:0]    wr_addr;

    assign ack_any = engine_ack | NUM_PORTS'(fast_ack);

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            eff_req[p]  = engine_req[p];
            eff_ch[p]   = engine_ch[p*CH_W +: CH_W];
            eff_data[p] = engine_data[p*DW +: DW];
            eff_eof[p]  = engine_eof[p];
            if (p < NUM_FAST) begin
                if (receive_port_control[p]) begin
                    eff_req[p]  = fast_req[p];
                    eff_ch[p]   = fast_ch[p*CH_W +: CH_W];
                    eff_data[p] = fast_data[p*DW +: DW];
                    eff_eof[p]  = fast_eof[p];
                end
            end
            // A port just acknowledged or aimed at a full channel waits
            eligible[p] = eff_req[p] && !ack_any[p] && (fill[eff_ch[p]] < REGION_FULL);
        end
    end

    assign port_pick = first_set(NUM_CH'(eligible));
    assign wr_en     = port_pick[CH_W];
    assign wr_port   = port_pick[PORT_W-1:0];
    assign wr_ch     = eff_ch[wr_port];
    assign wr_data   = eff_data[wr_port];
    assign wr_eof    = eff_eof[wr_port];
    assign wr_addr   = {wr_ch, wr_ptr[wr_ch]};

    // ==================================================================
    // Channel requests and selection
    logic [FILL_W-1:0]   high_words;
    logic [NUM_CH-1:0]   pend;
    logic [NUM_CH-1:0]   pend_upper;
    logic [CH_W:0]       pick_fixed;
    logic [CH_W:0]       pick_upper;
    logic [CH_W:0]       pick;

    assign high_words = FILL_W'({high_mark_blocks, 2'b00});

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            pend[c] = eof_pend[c]
                      || (fill[c] > high_words)
                      || (fill[c] == REGION_FULL);
            pend_upper[c] = pend[c] && (CH_W'(c) >= rr_ptr);
        end
    end

    assign pick_fixed = first_set(pend);
    assign pick_upper = first_set(pend_upper);
    assign pick       = (rr_mode && pick_upper[CH_W]) ? pick_upper : pick_fixed;

    // ==================================================================
    // Read side
    logic                buf_in_ready;
    logic                rd_en;
    logic                same_ch;
    logic                last_word;
    logic [ADDR_W-1:0]   rd_addr;
    logic [DW:0]         rd_word;

    assign same_ch   = wr_en && (wr_ch == cur_ch);
    assign rd_en     = (state == HRF_SERVE) && buf_in_ready && (fill[cur_ch] != FILL_RESET);
    assign last_word = rd_en && (fill[cur_ch] == FILL_ONE) && !same_ch;
    assign rd_addr   = {cur_ch, rd_ptr[cur_ch]};
    assign rd_word   = store[rd_addr];

    // ==================================================================
    // Scheduler next values
    always_comb begin
        next_state      = state;
        next_cur_ch     = cur_ch;
        next_rr_ptr     = rr_ptr;
        next_dma_req    = |pend;
        next_dma_busy   = 1'b0;
        next_engine_ack = '0;
        next_fast_ack   = '0;
        if (wr_en) begin
            if ((int'(wr_port) < NUM_FAST) && receive_port_control[wr_port[0]]) begin
                next_fast_ack[wr_port[0]] = 1'b1;
            end else begin
                next_engine_ack[wr_port] = 1'b1;
            end
        end
        case (state)
            HRF_IDLE: begin
                if (pick[CH_W]) begin
                    next_state    = HRF_SERVE;
                    next_cur_ch   = pick[CH_W-1:0];
                    next_rr_ptr   = pick[CH_W-1:0] + 8'h01;
                    next_dma_busy = 1'b1;
                end
            end
            HRF_SERVE: begin
                next_dma_busy = 1'b1;
                if (last_word || (fill[cur_ch] == FILL_RESET)) begin
                    next_state    = HRF_IDLE;
                    next_dma_busy = 1'b0;
                end
            end
            default: begin
                next_state = HRF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= HRF_IDLE;
            cur_ch     <= RR_RESET;
            rr_ptr     <= RR_RESET;
            dma_req    <= 1'b0;
            dma_busy   <= 1'b0;
            dma_sel_ch <= RR_RESET;
            engine_ack <= '0;
            fast_ack   <= '0;
        end else begin
            state      <= next_state;
            cur_ch     <= next_cur_ch;
            rr_ptr     <= next_rr_ptr;
            dma_req    <= next_dma_req;
            dma_busy   <= next_dma_busy;
            dma_sel_ch <= next_cur_ch;
            engine_ack <= next_engine_ack;
            fast_ack   <= next_fast_ack;
        end
    end

    // ==================================================================
    // Store contents
    always_ff @(posedge clk) begin
        if (wr_en) begin
            store[wr_addr] <= {wr_eof, wr_data};
        end
    end

    // ==================================================================
    // Per-channel fill, pointers and end-of-frame flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                fill[c]   <= FILL_RESET;
                wr_ptr[c] <= PTR_RESET;
                rd_ptr[c] <= PTR_RESET;
            end
            eof_pend <= '0;
        end else begin
            if (wr_en) begin
                wr_ptr[wr_ch] <= wr_ptr[wr_ch] + 4'h1;
            end
            if (rd_en) begin
                rd_ptr[cur_ch] <= rd_ptr[cur_ch] + 4'h1;
            end
            if (wr_en && rd_en && same_ch) begin
                fill[cur_ch] <= fill[cur_ch];
            end else begin
                if (wr_en) begin
                    fill[wr_ch] <= fill[wr_ch] + FILL_ONE;
                end
                if (rd_en) begin
                    fill[cur_ch] <= fill[cur_ch] - FILL_ONE;
                end
            end
            // Emptying the channel drops its flag; a new end of frame wins
            if ((last_word || ((state == HRF_SERVE) && (fill[cur_ch] == FILL_RESET))) && !same_ch) begin
                eof_pend[cur_ch] <= 1'b0;
            end
            if (wr_en && wr_eof) begin
                eof_pend[wr_ch] <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Output buffer toward the DMA
    logic [OUT_W-1:0]    buf_out;

    hrf_skid_buf #(
        .W (OUT_W)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (rd_en),
        .in_ready  (buf_in_ready),
        .in_data   ({last_word, rd_word[DW], cur_ch, rd_word[DW-1:0]}),
        .out_valid (dma_valid),
        .out_ready (dma_ready),
        .out_data  (buf_out)
    );

    assign dma_data = buf_out[DW-1:0];
    assign dma_ch   = buf_out[DW +: CH_W];
    assign dma_eof  = buf_out[DW+CH_W];
    assign dma_last = buf_out[DW+CH_W+1];

endmodule

// ===== testbench/hrf_rx_sched_properties.sv
// Port-level checks for the receive FIFO scheduler
`timescale 1ns/1ps
module hrf_rx_sched_properties
    import hrf_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Engine side
    input  wire logic [NUM_FAST-1:0]  receive_port_control,
    input  wire logic [NUM_PORTS-1:0] engine_req,
    input  wire logic [NUM_PORTS-1:0] engine_eof,
    input  wire logic [NUM_PORTS-1:0] engine_ack,
    input  wire logic [NUM_FAST-1:0]  fast_req,
    input  wire logic [NUM_FAST-1:0]  fast_ack,
    // DMA side
    input  wire logic                 dma_req,
    input  wire logic                 dma_busy,
    input  wire logic [CH_W-1:0]      dma_sel_ch,
    input  wire logic                 dma_valid,
    input  wire logic                 dma_ready,
    input  wire logic [DW-1:0]        dma_data,
    input  wire logic [CH_W-1:0]      dma_ch
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Sequences
    sequence s_stalled;
        dma_valid && !dma_ready;
    endsequence
    sequence s_eof_taken;
        |(engine_ack & $past(engine_eof));
    endsequence
    // ==========
    // Properties
    property p_reset_clear;
        $rose(rst_n) |-> !dma_req && !dma_busy && !dma_valid && engine_ack == '0 && fast_ack == '0;
    endproperty
    property p_ack_pulse;
        ({fast_ack, engine_ack} & $past({fast_ack, engine_ack})) == '0;
    endproperty
    property p_ack_cause;
        ({fast_ack, engine_ack} & ~$past({fast_req, engine_req})) == '0;
    endproperty
    property p_one_grant;
        $onehot0({fast_ack, engine_ack});
    endproperty
    property p_fast_route;
        (fast_ack & ~$past(receive_port_control)) == '0 && (engine_ack[1:0] & $past(receive_port_control)) == '0;
    endproperty
    property p_valid_hold;
        s_stalled |=> dma_valid && $stable(dma_data) && $stable(dma_ch);
    endproperty
    property p_sel_stable;
        dma_busy && $past(dma_busy) |-> $stable(dma_sel_ch);
    endproperty
    property p_eof_req;
        s_eof_taken |-> ##[0:2] (dma_req || dma_busy);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_one_grant: assert property (p_one_grant) else $error("two ports granted at once");
    a_fast_route: assert property (p_fast_route) else $error("word taken from wrong engine");
    a_valid_hold: assert property (p_valid_hold) else $error("stalled word changed");
    a_sel_stable: assert property (p_sel_stable) else $error("channel changed inside burst");
    a_eof_req: assert property (p_eof_req) else $error("end of frame not scheduled");
endmodule

bind hrf_rx_sched hrf_rx_sched_properties u_props (.clk(clk), .rst_n(rst_n),
    .receive_port_control(receive_port_control), .engine_req(engine_req), .engine_eof(engine_eof),
    .engine_ack(engine_ack), .fast_req(fast_req), .fast_ack(fast_ack), .dma_req(dma_req), .dma_busy(dma_busy),
    .dma_sel_ch(dma_sel_ch), .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_data(dma_data), .dma_ch(dma_ch));

// ===== testbench/hrf_dma_sink.sv
// Receive DMA model that takes burst words, slow at random or blocked on command
`timescale 1ns/1ps
module hrf_dma_sink (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Burst side
    output logic      dma_ready,
    // Test control
    input  wire logic stall
);
    // Stall stands for a host bus that is not granted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) dma_ready <= 1'b0;
        else dma_ready <= !stall && ($urandom_range(3) != 0);
    end
endmodule

// ===== testbench/hrf_rx_sched_tb.sv
// Self-checking bench for the receive FIFO scheduler
`timescale 1ns/1ps
module hrf_rx_sched_tb
    import hrf_pkg::*;
;
    logic                      clk, rst_n, rr_mode, stall, dma_req, dma_busy, dma_valid, dma_ready;
    logic                      dma_eof, dma_last, was_busy, ok;
    logic [NUM_FAST-1:0]       receive_port_control, fast_req, fast_eof, fast_ack;
    logic [HWM_W-1:0]          high_mark_blocks;
    logic [NUM_PORTS-1:0]      engine_req, engine_eof, engine_ack;
    logic [NUM_PORTS*CH_W-1:0] engine_ch;
    logic [NUM_PORTS*DW-1:0]   engine_data;
    logic [NUM_FAST*CH_W-1:0]  fast_ch;
    logic [NUM_FAST*DW-1:0]    fast_data;
    logic [DW-1:0]             dma_data, d;
    logic [CH_W-1:0]           dma_sel_ch, dma_ch;
    logic [DW:0]               note;
    logic [DW:0]               exp_q[NUM_CH][$];
    logic [CH_W-1:0]           sel_q[$];
    int                        fails, checked, pend, cycles, p;
    int                        got[$];
    int                        exp_sel[4];
    int                        pri_port[3] = '{3, 7, 12};
    logic [CH_W-1:0]           pri_ch[3] = '{8'hc8, 8'h64, 8'h01};

    hrf_rx_sched u_dut (.clk(clk), .rst_n(rst_n), .receive_port_control(receive_port_control),
        .high_mark_blocks(high_mark_blocks), .rr_mode(rr_mode), .engine_req(engine_req), .engine_ch(engine_ch),
        .engine_data(engine_data), .engine_eof(engine_eof), .engine_ack(engine_ack), .fast_req(fast_req),
        .fast_ch(fast_ch), .fast_data(fast_data), .fast_eof(fast_eof), .fast_ack(fast_ack), .dma_req(dma_req),
        .dma_busy(dma_busy), .dma_sel_ch(dma_sel_ch), .dma_valid(dma_valid), .dma_ready(dma_ready),
        .dma_data(dma_data), .dma_ch(dma_ch), .dma_eof(dma_eof), .dma_last(dma_last));
    hrf_dma_sink u_sink (.clk(clk), .rst_n(rst_n), .dma_ready(dma_ready), .stall(stall));

    // ==========
    // Tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic send(input int pt, input logic [CH_W-1:0] ch, input logic eof, input logic fst);
        logic [DW-1:0] w;
        int n;
        @(negedge clk);
        w = $urandom;
        exp_q[ch].push_back({eof, w});
        pend++;
        if (fst) begin
            fast_ch[pt*CH_W +: CH_W] = ch;
            fast_data[pt*DW +: DW] = w;
            fast_eof[pt] = eof;
            fast_req[pt] = 1'b1;
        end else begin
            engine_ch[pt*CH_W +: CH_W] = ch;
            engine_data[pt*DW +: DW] = w;
            engine_eof[pt] = eof;
            engine_req[pt] = 1'b1;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((fst ? fast_ack[pt] : engine_ack[pt]) !== 1'b1 && n < 50);
        if (fst) fast_req[pt] = 1'b0;
        else engine_req[pt] = 1'b0;
        check(n < 50, 1);
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (pend > 0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
        check(pend, 0);
        check({dma_busy, dma_valid}, 0);
    endtask

    // ==========
    // Clock, timeout and output watchers
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out;
        end
    end

    always @(posedge clk) begin
        if (dma_busy === 1'b1 && !was_busy) sel_q.push_back(dma_sel_ch);
        was_busy <= dma_busy === 1'b1;
        if (rst_n && dma_valid === 1'b1 && dma_ready === 1'b1) begin
            if (exp_q[dma_ch].size() == 0) check(1, 0);
            else begin
                note = exp_q[dma_ch].pop_front();
                pend--;
                check(dma_data, note[DW-1:0]);
                check(dma_eof, note[DW]);
                check(dma_last, exp_q[dma_ch].size() == 0);
            end
        end
    end

    // ==========
    // Test sequence
    initial begin
        void'($urandom(32'h3464));
        {rst_n, rr_mode, stall, receive_port_control, fast_req, fast_eof, fast_ch, fast_data} = '0;
        {engine_req, engine_eof, engine_ch, engine_data} = '0;
        high_mark_blocks = 3'h1;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) send(i, 8'h05, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check({dma_req, dma_busy}, 0);
        send(4, 8'h05, 1'b0, 1'b0);
        p = 0;
        while (dma_busy !== 1'b1 && p < 8) begin
            @(negedge clk);
            p++;
        end
        check(p < 8, 1);
        drain;
        $display("test threshold done");
        high_mark_blocks = 3'h7;
        @(negedge clk);
        foreach (pri_port[k]) begin
            p = pri_port[k];
            d = $urandom;
            {engine_ch[p*CH_W +: CH_W], engine_data[p*DW +: DW], engine_eof[p], engine_req[p]} = {pri_ch[k], d, 2'b11};
            exp_q[pri_ch[k]].push_back({1'b1, d});
            pend++;
        end
        repeat (20) begin
            @(negedge clk);
            for (int i = 0; i < NUM_PORTS; i++) if (engine_ack[i] === 1'b1) begin
                got.push_back(i);
                engine_req[i] = 1'b0;
            end
        end
        foreach (pri_port[k]) check(got[k], pri_port[k]);
        drain;
        $display("test port priority done");
        receive_port_control = 2'b01;
        engine_req[0] = 1'b1;
        engine_ch[CH_W-1:0] = 8'h1e;
        send(0, 8'h1f, 1'b1, 1'b1);
        check(engine_ack[0], 0);
        engine_req[0] = 1'b0;
        receive_port_control = 2'b10;
        send(1, 8'h21, 1'b1, 1'b1);
        send(0, 8'h22, 1'b1, 1'b0);
        drain;
        $display("test fast routing done");
        // Mark above region size: only a full region can start the burst
        stall = 1'b1;
        for (int i = 0; i < 16; i++) send(2, 8'h30, 1'b0, 1'b0);
        stall = 1'b0;
        drain;
        $display("test full region done");
        for (int m = 1; m >= 0; m--) begin
            rr_mode = m[0];
            stall = 1'b1;
            sel_q.delete();
            for (int i = 0; i < 4; i++) send(6, 8'h06, i == 3, 1'b0);
            send(2, 8'h08, 1'b1, 1'b0);
            send(4, 8'h02, 1'b1, 1'b0);
            send(5, 8'h04, 1'b1, 1'b0);
            stall = 1'b0;
            drain;
            if (m == 1) exp_sel = '{6, 8, 2, 4};
            else exp_sel = '{6, 2, 4, 8};
            foreach (exp_sel[k]) check(sel_q[k], exp_sel[k]);
        end
        $display("test channel selection done");
        // Port 1 still routed to its fast engine, so stay above it
        for (int i = 0; i < 3; i++) send(i + 2, 8'h14, 1'b0, 1'b0);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        check({dma_req, dma_busy, dma_valid, engine_ack, fast_ack}, 0);
        exp_q[8'h14].delete();
        pend -= 3;
        rst_n = 1'b1;
        send(3, 8'h14, 1'b1, 1'b0);
        drain;
        $display("test reset done");
        close_out;
    end
endmodule
